/* File: rtl/ccss_top.sv */
// Clock source selection for the codec: two control registers, the
// reference muxes for the PLL and the plain divider, and the core clock mux.
// Assumes a simple synchronous register port and clock pins already sampled
// on clk_in; the PLL and divider themselves live outside this block.
`timescale 1ns/1ps
module ccss_top (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic mclk_in,
  input wire logic bclk_in,
  input wire logic pll_divided_output_in,
  input wire logic plain_divider_output_in,
  output logic pll_reference_input_out,
  output logic plain_divider_input_out,
  output logic core_clock_input_out,
  output logic [4:0] pll_n_value_out
);

  // Stored select bit of the core clock source register.
  logic core_sel_q;
  // Stored clock generation control register.
  logic [7:0] clk_gen_q;
  // Registered read data.
  logic [7:0] rdata_q;
  // Registered mux outputs, so every data output comes from a flip-flop.
  logic pll_ref_q;
  logic div_in_q;
  logic core_clk_q;
  logic [4:0] nval_q;

  // Address decode for the two registers.
  wire logic hit_core_sel;
  wire logic hit_clk_gen;
  assign hit_core_sel = (reg_addr_in == ccss_pkg::CORE_SEL_OFFSET);
  assign hit_clk_gen = (reg_addr_in == ccss_pkg::CLK_GEN_OFFSET);

  // Field views of the control register.
  wire logic [1:0] div_src;
  wire logic [1:0] pll_src;
  wire logic [3:0] ndiv_code;
  assign div_src = clk_gen_q[ccss_pkg::DIV_SRC_HI:ccss_pkg::DIV_SRC_LO];
  assign pll_src = clk_gen_q[ccss_pkg::PLL_SRC_HI:ccss_pkg::PLL_SRC_LO];
  assign ndiv_code = clk_gen_q[ccss_pkg::NDIV_HI:ccss_pkg::NDIV_LO];

  // Reserved codes are never written by the host, so only the upper code
  // bit steers each mux; this keeps the mux a single gate level.
  wire logic div_use_bclk;
  wire logic pll_use_bclk;
  assign div_use_bclk = div_src[1];
  assign pll_use_bclk = pll_src[1];

  // Source muxes for the divider and the PLL reference.
  wire logic div_in_d;
  wire logic pll_ref_d;
  assign div_in_d = div_use_bclk ? bclk_in : mclk_in;
  assign pll_ref_d = pll_use_bclk ? bclk_in : mclk_in;

  // Core clock mux: 0 picks the PLL path, 1 the plain divider. A change while
  // both paths toggle can cut a pulse short; the host must park them first.
  wire logic core_clk_d;
  assign core_clk_d = core_sel_q ? plain_divider_output_in : pll_divided_output_in;

  // Read data: reserved upper bits of the select register read zero,
  // unmapped offsets read zero.
  wire logic [7:0] rdata_d;
  assign rdata_d = hit_core_sel ? {7'h00, core_sel_q} :
                   hit_clk_gen ? clk_gen_q : 8'h00;

  // Divide value decoded from the divider field.
  wire logic [4:0] nval_d;
  ccss_ndiv_decode u_ndec (
    .code_in(ndiv_code),
    .nval_out(nval_d)
  );

  // Register writes. Only bit 0 of the select register is stored, so
  // a stray write to the reserved bits has no effect.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      core_sel_q <= ccss_pkg::CORE_SEL_RESET[ccss_pkg::CORE_SEL_BIT];
      clk_gen_q <= ccss_pkg::CLK_GEN_RESET;
    end else if (reg_wr_in) begin
      if (hit_core_sel) begin
        core_sel_q <= reg_wdata_in[ccss_pkg::CORE_SEL_BIT];
      end
      if (hit_clk_gen) begin
        clk_gen_q <= reg_wdata_in;
      end
    end
  end

  // Output stage: one flop per output, giving a fixed one-cycle latency.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_q <= 8'h00;
      pll_ref_q <= 1'b0;
      div_in_q <= 1'b0;
      core_clk_q <= 1'b0;
      // The reset code sits above the two wrap codes, so its value is the code itself.
      nval_q <= {1'b0, ccss_pkg::CLK_GEN_RESET[ccss_pkg::NDIV_HI:ccss_pkg::NDIV_LO]};
    end else begin
      rdata_q <= rdata_d;
      pll_ref_q <= pll_ref_d;
      div_in_q <= div_in_d;
      core_clk_q <= core_clk_d;
      nval_q <= nval_d;
    end
  end

  // Drive the ports from the flops.
  assign reg_rdata_out = rdata_q;
  assign pll_reference_input_out = pll_ref_q;
  assign plain_divider_input_out = div_in_q;
  assign core_clock_input_out = core_clk_q;
  assign pll_n_value_out = nval_q;

  // Checks below share one hazard: the flops still see reset at the edge where
  // it is released, while the assertions already run at that edge. Every check
  // that compares a flop with its inputs, except a_ndiv_wrap and a_ndiv_literal, is therefore gated by the sampled reset,
  // or a reset in mid-run would look like a mux that ignored its select.
  // The core clock follows the PLL path when the select bit is clear.
  a_core_pll_path: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !sys_rst_in && !core_sel_q |=> core_clock_input_out == $past(pll_divided_output_in))
    else $error("Core clock does not follow PLL path.");

  // The core clock follows the divider path when the select bit is set.
  a_core_div_path: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !sys_rst_in && core_sel_q |=> core_clock_input_out == $past(plain_divider_output_in))
    else $error("Core clock does not follow divider path.");

  // Reserved bits of the select register always read back zero.
  a_reserved_read_zero: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !sys_rst_in && hit_core_sel |=> reg_rdata_out[7:1] == 7'h00)
    else $error("Reserved select bits read nonzero.");

  // Divider input source follows its field when the bit clock is chosen.
  a_div_src_mux: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !sys_rst_in && (div_src == ccss_pkg::SRC_BCLK) |=> plain_divider_input_out == $past(bclk_in))
    else $error("Divider input not taken from bit clock.");

  // PLL reference source follows its field when the master clock is chosen.
  a_pll_src_mux: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !sys_rst_in && (pll_src == ccss_pkg::SRC_MCLK) |=> pll_reference_input_out == $past(mclk_in))
    else $error("PLL reference not taken from master clock.");

  // Divider code one, held for two cycles, decodes to seventeen.
  a_ndiv_wrap: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    (ndiv_code == ccss_pkg::NCODE_17) ##1 (ndiv_code == ccss_pkg::NCODE_17) |-> pll_n_value_out == ccss_pkg::NVAL_17)
    else $error("Divider code one does not give seventeen.");

  // A written divider code other than zero or one shows on the value output two cycles later.
  a_ndiv_literal: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    reg_wr_in && hit_clk_gen && reg_wdata_in[3:1] != 3'h0
    |=> ##1 pll_n_value_out == {1'b0, $past(reg_wdata_in[3:0], 2)})
    else $error("Divider code not decoded to its own value.");

  // Right after reset both registers hold their defaults.
  a_reset_default: assert property (
    @(posedge clk_in)
    $fell(sys_rst_in) |-> clk_gen_q == ccss_pkg::CLK_GEN_RESET &&
    core_sel_q == ccss_pkg::CORE_SEL_RESET[ccss_pkg::CORE_SEL_BIT])
    else $error("Clock control register not at reset default.");

  // Divider input source follows its field when the master clock is chosen.
  a_div_mclk_path: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !sys_rst_in && div_src == ccss_pkg::SRC_MCLK |=> plain_divider_input_out == $past(mclk_in))
    else $error("Divider input not taken from master clock.");

  // PLL reference follows its field when the bit clock is chosen.
  a_pll_bclk_path: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !sys_rst_in && pll_src == ccss_pkg::SRC_BCLK |=> pll_reference_input_out == $past(bclk_in))
    else $error("PLL reference not taken from bit clock.");

  // Divider code zero decodes to sixteen one cycle later.
  a_ndiv_sixteen: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !sys_rst_in && ndiv_code == ccss_pkg::NCODE_16 |=> pll_n_value_out == ccss_pkg::NVAL_16)
    else $error("Divider code zero does not give sixteen.");

  // The select bit reads back as stored before any same-edge write.
  a_sel_readback: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !sys_rst_in && hit_core_sel |=> reg_rdata_out[ccss_pkg::CORE_SEL_BIT] == $past(core_sel_q))
    else $error("Select bit does not read back.");

  // The clock generation register reads back whole.
  a_gen_readback: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !sys_rst_in && hit_clk_gen |=> reg_rdata_out == $past(clk_gen_q))
    else $error("Clock generation register does not read back.");

  // A write to the clock generation register lands at the next edge.
  a_gen_write_lands: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !sys_rst_in && reg_wr_in && hit_clk_gen |=> clk_gen_q == $past(reg_wdata_in))
    else $error("Clock generation write not stored.");

  // A write to the select register stores only its low bit.
  a_sel_write_lands: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !sys_rst_in && reg_wr_in && hit_core_sel |=> core_sel_q == $past(reg_wdata_in[ccss_pkg::CORE_SEL_BIT]))
    else $error("Select write not stored.");

  // Right after reset the divide value is two.
  a_reset_nval: assert property (
    @(posedge clk_in)
    $fell(sys_rst_in) |-> pll_n_value_out == 5'h02)
    else $error("Divide value not two after reset.");

  // Offsets outside the two registers read zero.
  a_unmapped_zero: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    !sys_rst_in && !hit_core_sel && !hit_clk_gen |=> reg_rdata_out == 8'h00)
    else $error("Unmapped offset reads nonzero.");

endmodule // ccss_top

/* File: common/ccss_pkg.sv */
// Constants for the codec clock source selection block: register offsets,
// field positions, reset values and divider decode figures.
// Assumes an 8-bit register port with 8-bit offsets, sampled on one clock.
//
// What this block does
// - Core clock from PLL divider or plain divider.
// - Select register upper bits reserved, read zero.
// - Field D7-D6 picks master or bit clock for divider.
// - Field D5-D4 picks master or bit clock for PLL.
// - Divider code 0000 gives 16, 0001 gives 17.
// - Reset: divider code 0010, both sources master clock.
package ccss_pkg;

  // Register width of both registers.
  localparam int unsigned REG_W = 8;

  // Offsets of the two registers on the register port.
  localparam logic [7:0] CORE_SEL_OFFSET = 8'h65;
  localparam logic [7:0] CLK_GEN_OFFSET = 8'h66;

  // Field positions inside the core clock source select register.
  localparam int unsigned CORE_SEL_BIT = 0;

  // Field positions inside the clock generation control register.
  localparam int unsigned DIV_SRC_HI = 7;
  localparam int unsigned DIV_SRC_LO = 6;
  localparam int unsigned PLL_SRC_HI = 5;
  localparam int unsigned PLL_SRC_LO = 4;
  localparam int unsigned NDIV_HI = 3;
  localparam int unsigned NDIV_LO = 0;

  // Reset values of the two registers.
  localparam logic [7:0] CORE_SEL_RESET = 8'h00;
  localparam logic [7:0] CLK_GEN_RESET = 8'h02;

  // Source field codes; 01 and 11 are reserved.
  localparam logic [1:0] SRC_MCLK = 2'h0;
  localparam logic [1:0] SRC_BCLK = 2'h2;

  // Divider decode: the two lowest codes map to values above fifteen.
  localparam int unsigned NVAL_W = 5;
  localparam logic [3:0] NCODE_16 = 4'h0;
  localparam logic [3:0] NCODE_17 = 4'h1;
  localparam logic [4:0] NVAL_16 = 5'h10;
  localparam logic [4:0] NVAL_17 = 5'h11;

endpackage

/* File: rtl/ccss_ndiv_decode.sv */
// Decoder that turns the four-bit PLL divider code into its divide value.
// Assumes a code from the clock generation control register; purely combinational.
`timescale 1ns/1ps
module ccss_ndiv_decode (
  input wire logic [3:0] code_in,
  output logic [4:0] nval_out
);

  // The two lowest codes wrap to sixteen and seventeen, all others are literal.
  function automatic logic [4:0] ccss_ndecode(input logic [3:0] code);
    logic [4:0] val;
    val = {1'b0, code};
    if (code == ccss_pkg::NCODE_16) begin
      val = ccss_pkg::NVAL_16;
    end else if (code == ccss_pkg::NCODE_17) begin
      val = ccss_pkg::NVAL_17;
    end
    return val;
  endfunction

  // Continuous decode, no state.
  assign nval_out = ccss_ndecode(code_in);

endmodule // ccss_ndiv_decode

/* File: bench/ccss_host_model.sv */
// Host model: turns bench requests into one-cycle register writes.
// Assumes the bench raises go_in for one cycle per write.
`timescale 1ns/1ps
module ccss_host_model (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic rude_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] data_in,
  output logic reg_wr_out,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out
);
  // A polite host clears reserved bits and keeps source codes to 00 or 10.
  logic [7:0] clean_w;
  assign clean_w = (addr_in == ccss_pkg::CORE_SEL_OFFSET) ? {7'h00, data_in[0]} : (data_in & 8'haf);
  // Data lines toggle when idle so a stale value is never mistaken for a write.
  always @(posedge clk_in) begin
    reg_wr_out <= go_in;
    reg_addr_out <= addr_in;
    reg_wdata_out <= go_in ? (rude_in ? data_in : clean_w) : ~reg_wdata_out;
  end
endmodule // ccss_host_model

/* File: bench/testbench.sv */
// Self-checking bench for the clock source selection block.
// Assumes the package and host model are compiled first.
`timescale 1ns/1ps
module testbench;
  logic clk_in, sys_rst_in, go, rude, mclk_in, bclk_in, pdiv, cdiv, sel, w_wr;
  logic core_out, ref_out, div_in_out;
  logic [7:0] addr, data, w_addr, w_data, rdata;
  logic [4:0] n_out;
  logic [1:0] dsrc, psrc;
  logic [3:0] code;
  int bad_count, checked;
  ccss_host_model host (.clk_in(clk_in), .go_in(go), .rude_in(rude), .addr_in(addr), .data_in(data),
    .reg_wr_out(w_wr), .reg_addr_out(w_addr), .reg_wdata_out(w_data));
  ccss_top dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_wr_in(w_wr), .reg_addr_in(w_addr),
    .reg_wdata_in(w_data), .reg_rdata_out(rdata), .mclk_in(mclk_in), .bclk_in(bclk_in),
    .pll_divided_output_in(pdiv), .plain_divider_output_in(cdiv), .pll_reference_input_out(ref_out),
    .plain_divider_input_out(div_in_out), .core_clock_input_out(core_out), .pll_n_value_out(n_out));
  // Logs a mismatch between seen and expected.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Prints the counts and the verdict.
  task automatic summarize();
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Divide value expected for a divider code.
  function automatic logic [7:0] nexp(input logic [3:0] c);
    if (c == ccss_pkg::NCODE_16) return {3'h0, ccss_pkg::NVAL_16};
    if (c == ccss_pkg::NCODE_17) return {3'h0, ccss_pkg::NVAL_17};
    return {4'h0, c};
  endfunction
  // One write; clock pins are parked low first so switching never glitches.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic r);
    @(posedge clk_in);
    {mclk_in, bclk_in, pdiv, cdiv} <= 4'h0;
    go <= 1'b1;
    addr <= a;
    data <= d;
    rude <= r;
    @(posedge clk_in);
    go <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask
  // One read; data comes one edge behind the host's address stage.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr <= a;
    repeat (3) @(posedge clk_in);
    #1 check(rdata, exp);
  endtask
  // Free-running system clock.
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Main sequence: reset values, every divider code, random routing, reset again.
  initial begin
    sys_rst_in = 1'b1;
    {go, rude, mclk_in, bclk_in, pdiv, cdiv} = 6'h00;
    addr = 8'h00;
    data = 8'h00;
    bad_count = 0;
    checked = 0;
    void'($urandom(32'hbe5b2834));
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    #1 check(8'(n_out), 8'h02);
    rd(ccss_pkg::CORE_SEL_OFFSET, 8'h00);
    rd(ccss_pkg::CLK_GEN_OFFSET, 8'h02);
    rd(8'h67, 8'h00);
    wr(ccss_pkg::CORE_SEL_OFFSET, 8'hff, 1'b1);
    rd(ccss_pkg::CORE_SEL_OFFSET, 8'h01);
    for (int i = 0; i < 16; i++) begin
      wr(ccss_pkg::CLK_GEN_OFFSET, 8'(i), 1'b0);
      #1 check(8'(n_out), nexp(4'(i)));
    end
    for (int k = 0; k < 24; k++) begin
      sel = 1'($urandom);
      dsrc = {1'($urandom), 1'b0};
      psrc = {1'($urandom), 1'b0};
      code = 4'($urandom);
      wr(ccss_pkg::CORE_SEL_OFFSET, {7'h00, sel}, 1'b0);
      wr(ccss_pkg::CLK_GEN_OFFSET, {dsrc, psrc, code}, 1'b0);
      #1 check(8'(n_out), nexp(code));
      rd(ccss_pkg::CORE_SEL_OFFSET, {7'h00, sel});
      rd(ccss_pkg::CLK_GEN_OFFSET, {dsrc, psrc, code});
      repeat (8) begin
        @(posedge clk_in);
        {mclk_in, bclk_in, pdiv, cdiv} <= 4'($urandom);
        @(posedge clk_in);
        #1 check(8'(core_out), 8'(sel ? cdiv : pdiv));
        check(8'(div_in_out), 8'(dsrc[1] ? bclk_in : mclk_in));
        check(8'(ref_out), 8'(psrc[1] ? bclk_in : mclk_in));
      end
    end
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd(ccss_pkg::CLK_GEN_OFFSET, 8'h02);
    rd(ccss_pkg::CORE_SEL_OFFSET, 8'h00);
    check(8'(n_out), 8'h02);
    summarize();
  end
endmodule // testbench
